// file: src/tss_top.sv
// trigger step sequencer: ahb-lite registers, step queue and step executor
// Operation
// - a step with command nibble 0000 performs the control action named by its option nibble.
// - command 0001 adds the adjust register to the target register picked by the option.
// - the copy form of command 0001 moves the hold register into the target register picked by the option.
// - commands 001x write the five-bit value of command bit 0 and option into the adc positive input select.
// - command 0100 stalls until the selected trigger input rises; the source must supply that edge.
// - command 0101 stalls until the selected trigger input falls; the source must supply that edge.
// - command 0111 pulses the one interrupt request line named by the option.
// - commands 100x pulse the one trigger output named by command bit 0 and option.
// - commands 101x load the queue pointer with the five-bit target and continue there.
// - commands 110x only advance when loop counter a equals its limit, else count it up and jump.
// - commands 111x only advance when loop counter b equals its limit, else count it up and jump.
// - command 0110 and reserved options consume a step and change nothing else.
module tss_top
  import tss_pkg::*;
(
  // clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  SRST,
  // ahb-lite slave
  input  wire logic                  HSEL,
  input  wire logic [DATA_W-1:0]     HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [DATA_W-1:0]     HWDATA,
  input  wire logic                  HREADY,
  output logic      [DATA_W-1:0]     HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  // peripheral side
  input  wire logic [TRIG_IN_W-1:0]  TRIG_IN,
  output logic      [TRIG_OUT_W-1:0] TRIG_OUT,
  output logic      [IRQ_W-1:0]      IRQ_OUT,
  output logic      [4:0]            ADC_POS_SEL
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  tss_state_t             state_ff, nxt_state;
  logic                   run_ff, nxt_run;
  logic [PTR_W-1:0]       qptr_ff, nxt_qptr;
  logic [REG_W-1:0]       adj_ff, hold_ff;
  logic [REG_W-1:0]       cnt_a_ff, nxt_cnt_a, lim_a_ff, nxt_lim_a;
  logic [REG_W-1:0]       cnt_b_ff, nxt_cnt_b, lim_b_ff, nxt_lim_b;
  logic [4:0]             adc_sel_ff, nxt_adc_sel;
  logic [7:0]             queue_ff [QUEUE_DEPTH];
  logic [TRIG_IN_W-1:0]   trig_prev_ff;
  logic [TRIG_OUT_W-1:0]  trig_ff;
  logic [IRQ_W-1:0]       irq_ff;
  logic                   ph_wr_ff;
  logic [OFS_W-1:0]       ph_ofs_ff;
  logic [DATA_W-1:0]      rdata_ff;

  // bus address phase and data-phase write strobes
  wire              bus_take = HSEL & HTRANS[1] & HREADY;
  wire [OFS_W-1:0]  rd_ofs   = HADDR[OFS_W-1:0];
  wire              idle     = (state_ff == ST_IDLE);
  wire              wr_ctrl  = ph_wr_ff && (ph_ofs_ff == OFS_CTRL);
  wire              wr_adj   = ph_wr_ff && (ph_ofs_ff == OFS_ADJ);
  wire              wr_hold  = ph_wr_ff && (ph_ofs_ff == OFS_HOLD);
  wire              wr_qptr  = ph_wr_ff && (ph_ofs_ff == OFS_QPTR) && idle;
  wire              wr_cnt_a = ph_wr_ff && (ph_ofs_ff == OFS_CNT_A) && idle;
  wire              wr_lim_a = ph_wr_ff && (ph_ofs_ff == OFS_LIM_A);
  wire              wr_cnt_b = ph_wr_ff && (ph_ofs_ff == OFS_CNT_B) && idle;
  wire              wr_lim_b = ph_wr_ff && (ph_ofs_ff == OFS_LIM_B);
  wire              wr_adc   = ph_wr_ff && (ph_ofs_ff == OFS_ADCSEL);
  wire [REG_W-1:0]  wdata16  = HWDATA[REG_W-1:0];

  // step fetch and decode
  wire [7:0]        step_byte  = queue_ff[qptr_ff];
  wire [3:0]        cmd        = step_byte[7:4];
  wire [3:0]        opt        = step_byte[3:0];
  wire [4:0]        target5    = {cmd[0], opt};
  wire              exec       = (state_ff == ST_EXEC) && run_ff;
  wire              is_ctrl    = (cmd == CMD_CONTROL);
  wire              is_addcopy = (cmd == CMD_ADD_COPY);
  wire              is_copy    = is_addcopy && opt[3];
  wire              is_add     = is_addcopy && !opt[3];
  wire [2:0]        tgt        = opt[2:0];
  wire              is_strobe  = (cmd[3:1] == PFX_STROBE);
  wire              is_wait    = (cmd == CMD_WAIT_RISE) || (cmd == CMD_WAIT_FALL);
  wire              is_irq     = (cmd == CMD_IRQ);
  wire              is_trig    = (cmd[3:1] == PFX_TRIG);
  wire              is_jump    = (cmd[3:1] == PFX_JUMP);
  wire              is_loop_a  = (cmd[3:1] == PFX_LOOP_A);
  wire              is_loop_b  = (cmd[3:1] == PFX_LOOP_B);
  wire              loop_a_go  = is_loop_a && (cnt_a_ff != lim_a_ff);
  wire              loop_b_go  = is_loop_b && (cnt_b_ff != lim_b_ff);
  wire              jump_taken = is_jump || loop_a_go || loop_b_go;
  wire              ctrl_halt  = exec && is_ctrl && (opt == OPT_CTRL_HALT);

  // edge detection on the selected trigger input while stalled
  wire [TRIG_IN_W-1:0] rise_vec = TRIG_IN & ~trig_prev_ff;
  wire [TRIG_IN_W-1:0] fall_vec = ~TRIG_IN & trig_prev_ff;
  wire              wait_rise  = (cmd == CMD_WAIT_RISE);
  wire              in_wait    = (state_ff == ST_WAIT) && run_ff;
  wire              wait_hit   = in_wait && (wait_rise ? rise_vec[opt] : fall_vec[opt]);
  wire              step_done  = (exec && !is_wait && !jump_taken) || wait_hit;

  // add and copy write targets
  wire [REG_W-1:0]  src_val    = is_copy ? hold_ff : adj_ff;
  wire              ac_go      = exec && is_addcopy;
  wire              ac_lim_a   = ac_go && (tgt == TGT_LIM_A);
  wire              ac_lim_b   = ac_go && (tgt == TGT_LIM_B);
  wire              ac_cnt_a   = ac_go && (tgt == TGT_CNT_A);
  wire              ac_cnt_b   = ac_go && (tgt == TGT_CNT_B);

  // run flag: software write beats the halt step
  assign nxt_run = wr_ctrl ? HWDATA[CTRL_RUN_BIT] : (ctrl_halt ? 1'b0 : run_ff);

  // queue pointer: taken jumps load the target, finished steps step on
  assign nxt_qptr = wr_qptr ? HWDATA[PTR_W-1:0] :
                    (exec && jump_taken) ? target5 :
                    step_done ? PTR_W'(qptr_ff + 5'h01) :
                    qptr_ff;

  // loop counters: clear, count, add or copy
  assign nxt_cnt_a = wr_cnt_a ? wdata16 :
                     (exec && is_ctrl && (opt == OPT_CTRL_CLR_A)) ? RST_REG :
                     (exec && loop_a_go) ? REG_W'(cnt_a_ff + 16'h0001) :
                     ac_cnt_a ? (is_copy ? src_val : REG_W'(cnt_a_ff + src_val)) :
                     cnt_a_ff;
  assign nxt_cnt_b = wr_cnt_b ? wdata16 :
                     (exec && is_ctrl && (opt == OPT_CTRL_CLR_B)) ? RST_REG :
                     (exec && loop_b_go) ? REG_W'(cnt_b_ff + 16'h0001) :
                     ac_cnt_b ? (is_copy ? src_val : REG_W'(cnt_b_ff + src_val)) :
                     cnt_b_ff;

  // loop limits: software or add/copy steps
  assign nxt_lim_a = ac_lim_a ? (is_copy ? src_val : REG_W'(lim_a_ff + src_val)) :
                     wr_lim_a ? wdata16 : lim_a_ff;
  assign nxt_lim_b = ac_lim_b ? (is_copy ? src_val : REG_W'(lim_b_ff + src_val)) :
                     wr_lim_b ? wdata16 : lim_b_ff;

  // adc positive input select
  assign nxt_adc_sel = (exec && is_strobe) ? target5 :
                       wr_adc ? HWDATA[4:0] : adc_sel_ff;

  // sequencer state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (run_ff) nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (!run_ff || ctrl_halt) nxt_state = ST_IDLE;
        else if (is_wait) nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!run_ff) nxt_state = ST_IDLE;
        else if (wait_hit) nxt_state = ST_EXEC;
      end
    endcase
  end

  // executor registers
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_ff     <= ST_IDLE;
      run_ff       <= 1'b0;
      qptr_ff      <= RST_PTR;
      cnt_a_ff     <= RST_REG;
      cnt_b_ff     <= RST_REG;
      lim_a_ff     <= RST_REG;
      lim_b_ff     <= RST_REG;
      adj_ff       <= RST_REG;
      hold_ff      <= RST_REG;
      adc_sel_ff   <= 5'h00;
      trig_prev_ff <= {TRIG_IN_W{1'b0}};
    end else begin
      state_ff     <= nxt_state;
      run_ff       <= nxt_run;
      qptr_ff      <= nxt_qptr;
      cnt_a_ff     <= nxt_cnt_a;
      cnt_b_ff     <= nxt_cnt_b;
      lim_a_ff     <= nxt_lim_a;
      lim_b_ff     <= nxt_lim_b;
      adj_ff       <= wr_adj ? wdata16 : adj_ff;
      hold_ff      <= wr_hold ? wdata16 : hold_ff;
      adc_sel_ff   <= nxt_adc_sel;
      trig_prev_ff <= TRIG_IN;
    end
  end

  // one-cycle trigger pulses, one flop per output line
  for (genvar g = 0; g < TRIG_OUT_W; g++) begin : g_trig
    always_ff @(posedge REF_CLK) begin
      if (SRST) trig_ff[g] <= 1'b0;
      else trig_ff[g] <= exec && is_trig && (target5 == 5'(g));
    end
  end

  // one-cycle interrupt request pulses
  for (genvar g = 0; g < IRQ_W; g++) begin : g_irq
    always_ff @(posedge REF_CLK) begin
      if (SRST) irq_ff[g] <= 1'b0;
      else irq_ff[g] <= exec && is_irq && (opt == 4'(g));
    end
  end

  // step queue, four bytes per word, lowest byte in the low lane
  for (genvar g = 0; g < QUEUE_WORDS; g++) begin : g_queue
    wire wr_word = ph_wr_ff && (ph_ofs_ff == OFS_W'(OFS_QUEUE + 4 * g));
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        queue_ff[4*g]   <= RST_STEP;
        queue_ff[4*g+1] <= RST_STEP;
        queue_ff[4*g+2] <= RST_STEP;
        queue_ff[4*g+3] <= RST_STEP;
      end else if (wr_word) begin
        queue_ff[4*g]   <= HWDATA[7:0];
        queue_ff[4*g+1] <= HWDATA[15:8];
        queue_ff[4*g+2] <= HWDATA[23:16];
        queue_ff[4*g+3] <= HWDATA[31:24];
      end
    end
  end

  // read selection during the address phase
  wire [4:0]        q_base  = {rd_ofs[4:2], 2'b00};
  wire [DATA_W-1:0] q_word  = {queue_ff[q_base + 5'd3], queue_ff[q_base + 5'd2],
                               queue_ff[q_base + 5'd1], queue_ff[q_base]};
  wire [DATA_W-1:0] status  = {16'h0000, 3'b000, qptr_ff, 6'b000000,
                               (state_ff == ST_WAIT), !idle};
  wire [DATA_W-1:0] rd_word =
      (rd_ofs[7:5] == QUEUE_PAGE) ? q_word :
      (rd_ofs == OFS_CTRL)   ? {31'h0000_0000, run_ff} :
      (rd_ofs == OFS_STATUS) ? status :
      (rd_ofs == OFS_ADJ)    ? {16'h0000, adj_ff} :
      (rd_ofs == OFS_HOLD)   ? {16'h0000, hold_ff} :
      (rd_ofs == OFS_QPTR)   ? {27'h000_0000, qptr_ff} :
      (rd_ofs == OFS_CNT_A)  ? {16'h0000, cnt_a_ff} :
      (rd_ofs == OFS_LIM_A)  ? {16'h0000, lim_a_ff} :
      (rd_ofs == OFS_CNT_B)  ? {16'h0000, cnt_b_ff} :
      (rd_ofs == OFS_LIM_B)  ? {16'h0000, lim_b_ff} :
      (rd_ofs == OFS_ADCSEL) ? {27'h000_0000, adc_sel_ff} : RD_ZERO;

  // ahb data phase capture; zero wait states, always okay
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ph_wr_ff  <= 1'b0;
      ph_ofs_ff <= {OFS_W{1'b0}};
      rdata_ff  <= RD_ZERO;
    end else begin
      ph_wr_ff  <= bus_take && HWRITE;
      ph_ofs_ff <= bus_take ? rd_ofs : ph_ofs_ff;
      rdata_ff  <= (bus_take && !HWRITE) ? rd_word : RD_ZERO;
    end
  end

  // outputs
  assign HRDATA      = rdata_ff;
  assign HREADYOUT   = 1'b1;
  assign HRESP       = 1'b0;
  assign TRIG_OUT    = trig_ff;
  assign IRQ_OUT     = irq_ff;
  assign ADC_POS_SEL = adc_sel_ff;

  // checks on the executor
  sequence seq_wait_hit;
    wait_hit ##1 (state_ff == ST_EXEC);
  endsequence
  sequence seq_wait_hold;
    in_wait && !wait_hit && run_ff ##1 $stable(qptr_ff);
  endsequence

  chk_wait_release: assert property (wait_hit |-> seq_wait_hit)
    else $error("wait step did not release on its edge");
  chk_wait_stall: assert property (in_wait && !wait_hit && !wr_ctrl |-> seq_wait_hold)
    else $error("pointer moved while stalled");
  chk_wait_enter: assert property (exec && is_wait |=> state_ff == ST_WAIT && $stable(qptr_ff))
    else $error("wait step did not stall");
  chk_ctrl_halt: assert property (ctrl_halt && !wr_ctrl |=> idle && !run_ff)
    else $error("halt step did not stop");
  chk_add_limit: assert property (ac_lim_a && is_add |=> lim_a_ff == $past(lim_a_ff) + $past(adj_ff))
    else $error("add step wrong sum");
  chk_copy_hold: assert property (ac_lim_b && is_copy |=> lim_b_ff == $past(hold_ff))
    else $error("copy step wrong value");
  chk_strobe_sel: assert property (exec && is_strobe |=> ADC_POS_SEL == $past(target5))
    else $error("adc select not loaded");
  chk_irq_pulse: assert property (exec && is_irq |=> $onehot(IRQ_OUT) && IRQ_OUT[$past(opt)])
    else $error("interrupt request wrong line");
  chk_trig_pulse: assert property (exec && is_trig |=> $onehot(TRIG_OUT) && TRIG_OUT[$past(target5)])
    else $error("trigger pulse wrong line");
  chk_trig_quiet: assert property (!(exec && is_trig) |=> TRIG_OUT == {TRIG_OUT_W{1'b0}})
    else $error("trigger pulse without a step");
  chk_jump_load: assert property (exec && is_jump |=> qptr_ff == $past(target5))
    else $error("jump target not loaded");
  chk_loop_a_go: assert property (exec && loop_a_go |=> cnt_a_ff == $past(cnt_a_ff) + 16'h0001
                                  && qptr_ff == $past(target5))
    else $error("loop a jump wrong");
  chk_loop_a_end: assert property (exec && is_loop_a && !loop_a_go |=> $stable(cnt_a_ff)
                                   && qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("loop a exit wrong");
  chk_loop_b_go: assert property (exec && loop_b_go |=> cnt_b_ff == $past(cnt_b_ff) + 16'h0001
                                  && qptr_ff == $past(target5))
    else $error("loop b jump wrong");
  chk_reserved_nop: assert property (exec && cmd == CMD_RESERVED |=> $stable(cnt_a_ff) && $stable(cnt_b_ff)
                                     && $stable(adc_sel_ff) && IRQ_OUT == {IRQ_W{1'b0}})
    else $error("reserved step changed state");
  chk_step_advance: assert property (step_done |=> qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("pointer did not advance");

  // wait release on the selected line, seen against the previous cycle
  sequence seq_rise_seen;
    in_wait && wait_rise && $rose(TRIG_IN[opt]);
  endsequence
  sequence seq_fall_seen;
    in_wait && !wait_rise && $fell(TRIG_IN[opt]);
  endsequence

  chk_rise_release: assert property (seq_rise_seen |=> state_ff == ST_EXEC
                                     && qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("rising wait did not move on");
  chk_fall_release: assert property (seq_fall_seen |=> state_ff == ST_EXEC
                                     && qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("falling wait did not move on");
  chk_wait_quiet: assert property (in_wait |=> TRIG_OUT == {TRIG_OUT_W{1'b0}} && IRQ_OUT == {IRQ_W{1'b0}})
    else $error("pulse while stalled");

  // counters, pointer and outputs around each step
  chk_add_count: assert property (ac_cnt_a && is_add |=> cnt_a_ff == $past(cnt_a_ff) + $past(adj_ff))
    else $error("add step wrong count");
  chk_clear_b: assert property (exec && is_ctrl && opt == OPT_CTRL_CLR_B |=> cnt_b_ff == RST_REG)
    else $error("clear step left counter b");
  chk_run_write: assert property (wr_ctrl |=> run_ff == $past(HWDATA[CTRL_RUN_BIT]))
    else $error("run flag not written");
  chk_loop_b_end: assert property (exec && is_loop_b && !loop_b_go |=> $stable(cnt_b_ff)
                                   && qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("loop b exit wrong");
  chk_halt_ptr: assert property (ctrl_halt |=> qptr_ff == $past(qptr_ff) + 5'h01)
    else $error("halt step did not step on");
  chk_idle_still: assert property (idle && !wr_qptr |=> $stable(qptr_ff))
    else $error("pointer moved while idle");
  chk_irq_quiet: assert property (!(exec && is_irq) |=> IRQ_OUT == {IRQ_W{1'b0}})
    else $error("interrupt request without a step");
  chk_strobe_hold: assert property (!(exec && is_strobe) && !wr_adc |=> $stable(ADC_POS_SEL))
    else $error("adc select moved without a strobe");

endmodule : tss_top

// file: src/tss_pkg.sv
// constants, register map and step encodings of the trigger step sequencer
package tss_pkg;
  // widths and sizes
  localparam int DATA_W       = 32;
  localparam int REG_W        = 16;
  localparam int PTR_W        = 5;
  localparam int QUEUE_DEPTH  = 32;
  localparam int QUEUE_WORDS  = 8;
  localparam int TRIG_IN_W    = 16;
  localparam int TRIG_OUT_W   = 32;
  localparam int IRQ_W        = 16;
  localparam int OFS_W        = 8;

  // register byte offsets
  localparam logic [OFS_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [OFS_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [OFS_W-1:0] OFS_ADJ    = 8'h08;
  localparam logic [OFS_W-1:0] OFS_HOLD   = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_QPTR   = 8'h10;
  localparam logic [OFS_W-1:0] OFS_CNT_A  = 8'h14;
  localparam logic [OFS_W-1:0] OFS_LIM_A  = 8'h18;
  localparam logic [OFS_W-1:0] OFS_CNT_B  = 8'h1c;
  localparam logic [OFS_W-1:0] OFS_LIM_B  = 8'h20;
  localparam logic [OFS_W-1:0] OFS_ADCSEL = 8'h24;
  localparam logic [OFS_W-1:0] OFS_QUEUE  = 8'h40;
  localparam logic [2:0]       QUEUE_PAGE = 3'h2;

  // field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_PTR_LSB  = 8;

  // reset values
  localparam logic [REG_W-1:0] RST_REG   = 16'h0000;
  localparam logic [PTR_W-1:0] RST_PTR   = 5'h00;
  localparam logic [7:0]       RST_STEP  = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

  // command nibbles and three-bit prefixes
  localparam logic [3:0] CMD_CONTROL   = 4'h0;
  localparam logic [3:0] CMD_ADD_COPY  = 4'h1;
  localparam logic [3:0] CMD_WAIT_RISE = 4'h4;
  localparam logic [3:0] CMD_WAIT_FALL = 4'h5;
  localparam logic [3:0] CMD_RESERVED  = 4'h6;
  localparam logic [3:0] CMD_IRQ       = 4'h7;
  localparam logic [2:0] PFX_STROBE    = 3'h1;
  localparam logic [2:0] PFX_TRIG      = 3'h4;
  localparam logic [2:0] PFX_JUMP      = 3'h5;
  localparam logic [2:0] PFX_LOOP_A    = 3'h6;
  localparam logic [2:0] PFX_LOOP_B    = 3'h7;

  // control options and add/copy targets
  localparam logic [3:0] OPT_CTRL_HALT  = 4'h1;
  localparam logic [3:0] OPT_CTRL_CLR_A = 4'h2;
  localparam logic [3:0] OPT_CTRL_CLR_B = 4'h3;
  localparam logic [2:0] TGT_LIM_A      = 3'h0;
  localparam logic [2:0] TGT_LIM_B      = 3'h1;
  localparam logic [2:0] TGT_CNT_A      = 3'h2;
  localparam logic [2:0] TGT_CNT_B      = 3'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} tss_state_t;
endpackage : tss_pkg

// file: tb/tss_periph.sv
// peripheral partner: drives the trigger inputs and counts trigger and interrupt pulses
module tss_periph
  import tss_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // levels commanded by the bench
  input  wire logic [TRIG_IN_W-1:0]  lvl,
  // sequencer side
  input  wire logic [TRIG_OUT_W-1:0] trig_out,
  input  wire logic [IRQ_W-1:0]      irq_out,
  output logic      [TRIG_IN_W-1:0]  trig_in,
  output int                         bad_pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  int trig_cnt [TRIG_OUT_W];
  int irq_cnt  [IRQ_W];

  // the source moves its lines only on the clock edge, each edge held at least one cycle
  always @(posedge clk) begin
    if (rst) begin
      trig_in <= '0;
    end else begin
      trig_in <= lvl;
    end
  end

  // tally every pulse; more than one trigger line or more than one interrupt line high at once is a fault
  initial begin
    bad_pulses = 0;
    foreach (trig_cnt[i]) trig_cnt[i] = 0;
    foreach (irq_cnt[i]) irq_cnt[i] = 0;
  end
  always @(posedge clk) begin
    if (!rst) begin
      foreach (trig_cnt[i]) trig_cnt[i] += int'(trig_out[i]);
      foreach (irq_cnt[i]) irq_cnt[i] += int'(irq_out[i]);
      if ($countones(trig_out) > 1 || $countones(irq_out) > 1) bad_pulses++;
    end
  end
endmodule : tss_periph

// file: tb/tss_top_tb.sv
// self-checking bench of the trigger step sequencer
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tss_top_tb;
  import tss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  REF_CLK = 1'b0;
  logic                  SRST    = 1'b1;
  logic                  HSEL    = 1'b0;
  logic                  HWRITE  = 1'b0;
  logic [DATA_W-1:0]     HADDR   = '0;
  logic [DATA_W-1:0]     HWDATA  = '0;
  logic [1:0]            HTRANS  = 2'h0;
  logic [2:0]            HSIZE   = 3'h2;
  logic [TRIG_IN_W-1:0]  lvl     = '0;
  wire  [DATA_W-1:0]     HRDATA;
  wire                   HREADYOUT;
  wire                   HRESP;
  wire  [TRIG_IN_W-1:0]  TRIG_IN;
  wire  [TRIG_OUT_W-1:0] TRIG_OUT;
  wire  [IRQ_W-1:0]      IRQ_OUT;
  wire  [4:0]            ADC_POS_SEL;
  int                    bad_pulses;
  int                    num_errors  = 0;
  int                    comparisons = 0;
  int                    cyc         = 0;
  logic [DATA_W-1:0]     rd_smp;
  logic [DATA_W-1:0]     rd;

  tss_top i_tss_top (.REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TRIG_IN(TRIG_IN), .TRIG_OUT(TRIG_OUT), .IRQ_OUT(IRQ_OUT),
    .ADC_POS_SEL(ADC_POS_SEL));
  tss_periph i_tss_periph (.clk(REF_CLK), .rst(SRST), .lvl(lvl), .trig_out(TRIG_OUT), .irq_out(IRQ_OUT),
    .trig_in(TRIG_IN), .bad_pulses(bad_pulses));

  // 40 MHz clock; read data captured exactly at the sampling edge
  always #12.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) rd_smp <= HRDATA;

  // hang guard
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // one single ahb-lite transfer: address phase, then data phase, each held until hready
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wr ? d : 32'h0;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    #1 q = rd_smp;
    `CHK(HRESP, 1'b0)
  endtask : ahb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb_xfer(1'b0, a, 32'h0, rd);
    `CHK(rd, e)
  endtask : rd_chk

  // poll status until the executor is idle again
  task automatic wait_halt();
    for (int n = 0; n < 100; n++) begin
      ahb_xfer(1'b0, OFS_STATUS, 32'h0, rd);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
  endtask : wait_halt

  // reset values, unmapped and read-only places, upper bits
  task automatic test_regs();
    logic [7:0] ofs [11] = '{OFS_CTRL, OFS_STATUS, OFS_ADJ, OFS_HOLD, OFS_QPTR, OFS_CNT_A, OFS_LIM_A,
                             OFS_CNT_B, OFS_LIM_B, OFS_ADCSEL, OFS_QUEUE};
    foreach (ofs[i]) rd_chk(ofs[i], RD_ZERO);
    `CHK(ADC_POS_SEL, 5'h00)
    wr(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, RD_ZERO);
    wr(OFS_STATUS, 32'hffff_ffff);
    rd_chk(OFS_STATUS, RD_ZERO);
    wr(OFS_ADJ, 32'hffff_ffff);
    rd_chk(OFS_ADJ, 32'h0000_ffff);
  endtask : test_regs

  // add, copy, strobe, reserved, clear, counted loop, trigger, interrupt, halt
  task automatic test_steps();
    wr(OFS_ADJ, 32'h0000_0005);
    wr(OFS_HOLD, 32'h0000_0003);
    wr(OFS_CNT_A, 32'h0000_0001);
    wr(OFS_CNT_B, 32'h0000_0002);
    wr(OFS_QUEUE, 32'h3560_1912);
    wr(OFS_QUEUE + 8'h04, 32'h93e5_8003);
    wr(OFS_QUEUE + 8'h08, 32'h0000_0174);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_halt();
    rd_chk(OFS_CNT_A, 32'h0000_0006);
    rd_chk(OFS_LIM_B, 32'h0000_0003);
    rd_chk(OFS_CNT_B, 32'h0000_0003);
    `CHK(ADC_POS_SEL, 5'h15)
    `CHK(i_tss_periph.trig_cnt[0], 4)
    `CHK(i_tss_periph.trig_cnt[19], 1)
    `CHK(i_tss_periph.irq_cnt[4], 1)
    rd_chk(OFS_QPTR, 32'h0000_000a);
    rd_chk(OFS_STATUS, 32'h0000_0a00);
    rd_chk(OFS_CTRL, RD_ZERO);
  endtask : test_steps

  // jump, rising and falling waits, loop on counter a
  task automatic test_waits();
    wr(OFS_QPTR, 32'h0000_0000);
    wr(OFS_LIM_A, 32'h0000_0001);
    wr(OFS_CNT_A, 32'h0000_0000);
    wr(OFS_QUEUE, 32'h8181_81a4);
    wr(OFS_QUEUE + 8'h04, 32'hc682_5242);
    wr(OFS_QUEUE + 8'h08, 32'h0000_012b);
    wr(OFS_CTRL, 32'h0000_0001);
    // the jump and the wait step need two cycles before the stall shows
    repeat (2) @(posedge REF_CLK);
    rd_chk(OFS_STATUS, 32'h0000_0403);
    wr(OFS_QPTR, 32'h0000_0009);
    rd_chk(OFS_QPTR, 32'h0000_0004);
    `CHK(i_tss_periph.trig_cnt[1], 0)
    @(posedge REF_CLK);
    lvl[2] <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    rd_chk(OFS_STATUS, 32'h0000_0503);
    @(posedge REF_CLK);
    lvl[2] <= 1'b0;
    wait_halt();
    rd_chk(OFS_CNT_A, 32'h0000_0001);
    `CHK(i_tss_periph.trig_cnt[2], 2)
    `CHK(ADC_POS_SEL, 5'h0b)
    rd_chk(OFS_QPTR, 32'h0000_000a);
    `CHK(i_tss_periph.bad_pulses, 0)
  endtask : test_waits

  // reset in mid-run while stalled: registers, queue and select go back to zero
  task automatic test_reset();
    wr(OFS_QPTR, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge REF_CLK);
    rd_chk(OFS_STATUS, 32'h0000_0403);
    @(posedge REF_CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'b0;
    rd_chk(OFS_STATUS, RD_ZERO);
    rd_chk(OFS_CNT_A, RD_ZERO);
    rd_chk(OFS_QUEUE + 8'h04, RD_ZERO);
    `CHK(ADC_POS_SEL, 5'h00)
  endtask : test_reset

  // main sequence
  initial begin
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'b0;
    test_regs();
    test_steps();
    test_waits();
    test_reset();
    print_verdict();
  end
endmodule : tss_top_tb
